// ### rtl/qdrpc_top.sv
// reference mode and channel register control for a quad converter
// assumes serial pins are asynchronous to ref_clk and idle-safe
`timescale 1ns/1ps
module qdrpc_top
   import qdrpc_pkg::*;
#(
   parameter logic [23:0] REF_AUTO_CMD = REF_AUTO_CMD_DEFAULT
)(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // serial link pins
   input wire logic sclkPin,
   input wire logic syncPinN,
   input wire logic dinPin,
   // address straps
   input wire logic [1:0] addrPin,
   // channel outputs
   output logic [3:0][15:0] chanCode,
   output logic [3:0][1:0] chanPdMode,
   // reference status
   output qdrpc_pkg::qdrpc_ref_e refMode,
   output logic refPowered,
   output logic referenceOutputPinOe
);
   import qdrpc_pkg::*;

   // whole decoder state
   typedef struct packed {
      qdrpc_ref_e mode; // reference setting
      logic [3:0][15:0] bufCode; // staged codes
      logic [3:0][1:0] bufPd; // staged power-down modes
      logic [3:0][15:0] dacCode; // live codes
      logic [3:0][1:0] dacPd; // live power-down modes
      logic refOn; // reference powered
      logic refOe; // reference pin driven
   } qdrpc_dec_s;

   qdrpc_dec_s s;
   qdrpc_dec_s next_s;
   qdrpc_link_if link ();

   // pin filter and frame assembly
   qdrpc_serial_rx u_rx (
      .ref_clk (ref_clk),
      .reset (reset),
      .pins ({sclkPin, syncPinN, dinPin, addrPin[1], addrPin[0]}),
      .link (link)
   );

   logic [23:0] w;
   logic [1:0] ld;
   logic [1:0] sel;
   logic addrHit;
   logic [15:0] newCode;
   logic [1:0] newPd;
   logic hit;
   logic anyActive;

   // command decode and reference mode
   always_comb begin
      next_s = s;
      w = link.frameWord;
      ld = w[LD_HI:LD_LO];
      sel = w[SEL_HI:SEL_LO];
      hit = 1'b0;
      addrHit = (w[ADDR_HI:ADDR_LO] == link.addrPins) || (ld == LD_BCAST);
      // bit 16 turns the data field into a power-down request
      newPd = w[CMD_BIT16] ? w[PDM_HI:PDM_LO] : PDM_ACTIVE;
      newCode = w[15:0]; // straight binary
      if (link.frameValid) begin
         if (w == REF_OFF_CMD) begin
            next_s.mode = QDRPC_REF_OFF;
         end else if (w == REF_ON_CMD) begin
            next_s.mode = QDRPC_REF_ON;
         end else if (w == REF_AUTO_CMD) begin
            next_s.mode = QDRPC_REF_AUTO;
         end else if (addrHit && !w[ZERO_BIT]) begin
            // per-channel load handling
            for (int i = 0; i < NUM_CHAN; i++) begin
               // broadcast ignores the select; bit 18 alone decides
               hit = (ld == LD_BCAST) ? w[SEL_HI] : (sel == i[1:0]);
               unique case (ld)
                  LD_STORE: begin
                     if (hit) begin
                        next_s.bufPd[i] = newPd;
                        if (!w[CMD_BIT16]) begin
                           next_s.bufCode[i] = newCode;
                        end
                     end
                  end
                  LD_UPDATE: begin
                     if (hit) begin
                        next_s.bufPd[i] = newPd;
                        next_s.dacPd[i] = newPd;
                        if (!w[CMD_BIT16]) begin
                           next_s.bufCode[i] = newCode;
                           next_s.dacCode[i] = newCode;
                        end
                     end
                  end
                  LD_SIMUL, LD_BCAST: begin
                     if (hit) begin
                        // selected channel takes the new word
                        next_s.bufPd[i] = newPd;
                        next_s.dacPd[i] = newPd;
                        if (!w[CMD_BIT16]) begin
                           next_s.bufCode[i] = newCode;
                           next_s.dacCode[i] = newCode;
                        end
                     end else begin
                        // others load what was staged
                        next_s.dacPd[i] = s.bufPd[i];
                        next_s.dacCode[i] = s.bufCode[i];
                     end
                  end
               endcase
            end
         end
      end
      anyActive = 1'b0;
      for (int i = 0; i < NUM_CHAN; i++) begin
         anyActive = anyActive | (next_s.dacPd[i] == PDM_ACTIVE);
      end
      // auto follows the channels, forced settings ignore them
      next_s.refOn = (next_s.mode == QDRPC_REF_ON) ||
                     ((next_s.mode == QDRPC_REF_AUTO) && anyActive);
      // pin left undriven whenever the reference is not running
      next_s.refOe = next_s.refOn;
   end

   // state register; channels stay live in every reference mode
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s.mode <= QDRPC_REF_AUTO;
         s.bufCode <= {4{CODE_RESET}};
         s.bufPd <= {4{PDM_ACTIVE}};
         s.dacCode <= {4{CODE_RESET}};
         s.dacPd <= {4{PDM_ACTIVE}};
         s.refOn <= 1'b1;
         s.refOe <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign chanCode = s.dacCode;
   assign chanPdMode = s.dacPd;
   assign refMode = s.mode;
   assign refPowered = s.refOn;
   assign referenceOutputPinOe = s.refOe;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   // command sequences and the all-channels-down condition
   sequence offCmd;
      link.frameValid && link.frameWord == REF_OFF_CMD;
   endsequence
   sequence onCmd;
      link.frameValid && link.frameWord == REF_ON_CMD;
   endsequence
   sequence autoCmd;
      link.frameValid && link.frameWord == REF_AUTO_CMD;
   endsequence
   sequence allDown;
      s.dacPd[0] != PDM_ACTIVE && s.dacPd[1] != PDM_ACTIVE &&
      s.dacPd[2] != PDM_ACTIVE && s.dacPd[3] != PDM_ACTIVE;
   endsequence

   after_reset_a: assert property (
      disable iff (1'b0)
      $past(reset) && !reset |-> s.mode == QDRPC_REF_AUTO && s.refOn)
      else $error("reference not automatic and on after reset");
   ref_off_a: assert property (
      offCmd |=> s.mode == QDRPC_REF_OFF && !s.refOn)
      else $error("disable word did not power reference down");
   off_tristate_a: assert property (
      offCmd ##1 (!link.frameValid)[*3] |-> !referenceOutputPinOe)
      else $error("reference pin driven while disabled");
   ref_auto_a: assert property (
      autoCmd |=> s.mode == QDRPC_REF_AUTO)
      else $error("restore word did not give automatic mode");
   auto_down_a: assert property (
      s.mode == QDRPC_REF_AUTO and allDown |-> !refPowered)
      else $error("reference up with all channels down");
   auto_up_a: assert property (
      s.mode == QDRPC_REF_AUTO && !$past(refPowered) &&
      (s.dacPd[0] == PDM_ACTIVE || s.dacPd[1] == PDM_ACTIVE ||
      s.dacPd[2] == PDM_ACTIVE || s.dacPd[3] == PDM_ACTIVE) |-> refPowered)
      else $error("reference stayed down after channel woke");
   ref_on_a: assert property (
      onCmd |=> s.mode == QDRPC_REF_ON ##1 refPowered)
      else $error("always-on word did not hold reference up");
   mode_hold_a: assert property (
      !link.frameValid |=> $stable(s.mode))
      else $error("reference mode moved without a frame");
   bcast_code_a: assert property (
      link.frameValid && link.frameWord[23:16] == 8'h34 |=>
      s.dacCode == {4{$past(link.frameWord[15:0])}})
      else $error("broadcast code not on all four channels");
   pd_bit_a: assert property (
      link.frameValid && link.frameWord[23:16] == 8'h35 &&
      link.frameWord[15:14] != PDM_ACTIVE |=>
      s.dacPd == {4{$past(link.frameWord[15:14])}})
      else $error("bit 16 did not power the channels down");
endmodule : qdrpc_top

// ### rtl/qdrpc_pkg.sv
// constants, field layout and types for the reference and channel control
// assumes one 100 MHz clock and a 24-bit serial command link
package qdrpc_pkg;
   // frame length and bit counter
   localparam int unsigned FRAME_BITS = 24;
   localparam logic [4:0] CNT_RESET = 5'h00;
   localparam logic [4:0] CNT_LAST = 5'h17;
   // reference command words
   localparam logic [23:0] REF_OFF_CMD = 24'h012000;
   localparam logic [23:0] REF_ON_CMD = 24'h011000;
   localparam logic [23:0] REF_AUTO_CMD_DEFAULT = 24'h010000;
   // field positions inside the command word
   localparam int unsigned ADDR_HI = 23;
   localparam int unsigned ADDR_LO = 22;
   localparam int unsigned LD_HI = 21;
   localparam int unsigned LD_LO = 20;
   localparam int unsigned ZERO_BIT = 19;
   localparam int unsigned SEL_HI = 18;
   localparam int unsigned SEL_LO = 17;
   localparam int unsigned CMD_BIT16 = 16;
   localparam int unsigned PDM_HI = 15;
   localparam int unsigned PDM_LO = 14;
   // load operations
   localparam logic [1:0] LD_STORE = 2'h0;
   localparam logic [1:0] LD_UPDATE = 2'h1;
   localparam logic [1:0] LD_SIMUL = 2'h2;
   localparam logic [1:0] LD_BCAST = 2'h3;
   // pin vector layout for the input synchroniser
   localparam int unsigned PIN_A0 = 0;
   localparam int unsigned PIN_A1 = 1;
   localparam int unsigned PIN_DIN = 2;
   localparam int unsigned PIN_SYNC = 3;
   localparam int unsigned PIN_SCLK = 4;
   localparam int unsigned PIN_COUNT = 5;
   // values after reset; frame select idles high
   localparam logic [4:0] PINS_RESET = 5'h08;
   localparam logic [23:0] WORD_RESET = 24'h000000;
   localparam logic [15:0] CODE_RESET = 16'h0000;
   localparam logic [1:0] PDM_ACTIVE = 2'h0;
   localparam int unsigned NUM_CHAN = 4;
   // reference setting, one-hot
   typedef enum logic [2:0] {
      QDRPC_REF_AUTO = 3'b001,
      QDRPC_REF_OFF = 3'b010,
      QDRPC_REF_ON = 3'b100
   } qdrpc_ref_e;
   typedef logic [15:0] qdrpc_code_t;
endpackage : qdrpc_pkg

// ### rtl/qdrpc_link_if.sv
// carrier from the serial receiver to the command decoder
// assumes both ends run on ref_clk
`timescale 1ns/1ps
interface qdrpc_link_if;
   logic frameValid; // one-cycle pulse: full word received
   logic [23:0] frameWord; // word, stands until next frame
   logic [1:0] addrPins; // filtered address straps
   modport rx (output frameValid, output frameWord, output addrPins);
   modport dec (input frameValid, input frameWord, input addrPins);
endinterface : qdrpc_link_if

// ### rtl/qdrpc_serial_rx.sv
// serial frame receiver: filters the pins and assembles 24-bit words
// assumes pins are asynchronous and far slower than ref_clk
`timescale 1ns/1ps
module qdrpc_serial_rx
   import qdrpc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // raw pins
   input wire logic [4:0] pins,
   // toward the decoder
   qdrpc_link_if.rx link
);
   // whole receiver state
   typedef struct packed {
      logic [4:0] s1; // first stage, read only by s2
      logic [4:0] s2;
      logic [4:0] s3;
      logic [4:0] stab; // value once s2 and s3 agree
      logic [23:0] shift;
      logic [4:0] count;
      logic locked; // 24 bits taken, ignore more clocks
      logic frameValid;
      logic [23:0] word;
   } qdrpc_rx_s;

   qdrpc_rx_s s;
   qdrpc_rx_s next_s;
   logic [4:0] newStab;
   logic sclkFall;

   // filter, shift and frame tracking
   always_comb begin
      next_s = s;
      next_s.s1 = pins;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      // take the level only where the two later stages agree
      newStab = (s.s2 & ~(s.s2 ^ s.s3)) | (s.stab & (s.s2 ^ s.s3));
      next_s.stab = newStab;
      sclkFall = s.stab[PIN_SCLK] & ~newStab[PIN_SCLK];
      next_s.frameValid = 1'b0;
      if (newStab[PIN_SYNC]) begin
         // frame select high: drop any partial frame
         next_s.count = CNT_RESET;
         next_s.locked = 1'b0;
      end else if (sclkFall && !s.locked) begin
         // msb first, one bit per falling edge
         next_s.shift = {s.shift[22:0], newStab[PIN_DIN]};
         next_s.count = s.count + 5'h01;
         if (s.count == CNT_LAST) begin
            next_s.locked = 1'b1;
            next_s.frameValid = 1'b1;
            next_s.word = {s.shift[22:0], newStab[PIN_DIN]};
         end
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s <= '{PINS_RESET, PINS_RESET, PINS_RESET, PINS_RESET,
                WORD_RESET, CNT_RESET, 1'b0, 1'b0, WORD_RESET};
      end else begin
         s <= next_s;
      end
   end

   assign link.frameValid = s.frameValid;
   assign link.frameWord = s.word;
   assign link.addrPins = {s.stab[PIN_A1], s.stab[PIN_A0]};

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   // a word is only reported on the 24th bit
   frame_len_a: assert property (
      s.frameValid |-> $past(s.count) == CNT_LAST && s.count == 5'h18)
      else $error("frame reported at wrong bit count");
   // a rise of frame select mid-word throws it away
   abort_frame_a: assert property (
      newStab[PIN_SYNC] && s.count != CNT_RESET && !s.locked
      |=> s.count == CNT_RESET ##1 !s.frameValid)
      else $error("partial frame not abandoned");
endmodule : qdrpc_serial_rx

// ### tb/qdrpc_host_model.sv
// host controller model: sends 24-bit command frames over three wires
// assumes it shares ref_clk with the device and is the only pin driver
`timescale 1ns/1ps
module qdrpc_host_model (
   // clock
   input wire logic ref_clk,
   // link pins
   output logic sclkPin,
   output logic syncPinN,
   output logic dinPin
);
   localparam realtime HALF_NS = 62.5; // link half period, 125 ns clock
   localparam int GAP = 6; // ref_clk cycles of frame setup and idle
   // idle: frame closed, link clock parked low
   initial begin
      sclkPin = 1'b0;
      syncPinN = 1'b1;
      dinPin = 1'b0;
   end
   // wait a number of ref_clk edges
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick
   // send the top nbits of word msb first, then close the frame
   task automatic send(input logic [23:0] word, input int nbits);
      tick(1);
      syncPinN <= 1'b0; // open the frame
      tick(GAP);
      // link clock is free of ref_clk, as on the real pins
      for (int i = 23; i > 23 - nbits; i--) begin
         dinPin <= word[i]; // msb first, steady over the fall
         sclkPin <= 1'b1;
         #(HALF_NS);
         sclkPin <= 1'b0; // device takes the bit here
         #(HALF_NS);
      end
      tick(4);
      syncPinN <= 1'b1; // early rise abandons a short frame
      dinPin <= ~dinPin; // released line does not keep its value
      tick(GAP);
   endtask : send
endmodule : qdrpc_host_model

// ### tb/tb_qdrpc_top.sv
// self-checking bench for reference mode and channel register control
// assumes the host model is the only link driver and straps stay 00
`timescale 1ns/1ps
module tb_qdrpc_top;
   import qdrpc_pkg::*;
   // restore word for this bench; bit 19 set so it means nothing else
   localparam logic [23:0] AUTO_WORD = 24'h080000;
   logic ref_clk = 1'b0; // 100 MHz
   logic reset = 1'b1; // synchronous, active high
   logic sclkPin;
   logic syncPinN;
   logic dinPin;
   logic [1:0] addrPin = 2'h0; // straps match address 00
   logic [3:0][15:0] chanCode;
   logic [3:0][1:0] chanPdMode;
   qdrpc_ref_e refMode;
   logic refPowered;
   logic referenceOutputPinOe;
   int n_errors = 0; // mismatches
   int tests_run = 0; // comparisons
   // clock generator
   always #5 ref_clk = ~ref_clk;
   // device under test
   qdrpc_top #(.REF_AUTO_CMD(AUTO_WORD)) qdrpc_top_inst (
      .ref_clk(ref_clk), .reset(reset), .sclkPin(sclkPin),
      .syncPinN(syncPinN), .dinPin(dinPin), .addrPin(addrPin),
      .chanCode(chanCode), .chanPdMode(chanPdMode), .refMode(refMode),
      .refPowered(refPowered),
      .referenceOutputPinOe(referenceOutputPinOe)
   );
   // far side of the link
   qdrpc_host_model qdrpc_host_model_inst (
      .ref_clk(ref_clk), .sclkPin(sclkPin), .syncPinN(syncPinN),
      .dinPin(dinPin)
   );
   // print counts and verdict, then end the run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test
   // compare one value
   task automatic chk(input string what, input logic [23:0] seen,
      input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // reference status: mode, power and pin drive together
   task automatic chk_ref(input logic [2:0] mode, input logic pwr);
      chk("refMode", {21'h0, refMode}, {21'h0, mode});
      chk("refPowered", {23'h0, refPowered}, {23'h0, pwr});
      chk("refPinOe", {23'h0, referenceOutputPinOe}, {23'h0, pwr});
   endtask : chk_ref
   // single-channel update of code, or power-down with a mode
   task automatic chan(input logic [1:0] sel, input logic pd,
      input logic [15:0] data);
      qdrpc_host_model_inst.send({4'h1, 1'b0, sel, pd, data}, 24);
   endtask : chan
   // hold reset four cycles and let the pin filter settle
   task automatic do_reset();
      reset <= 1'b1;
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask : do_reset
   // values straight after reset
   task automatic t_reset_values();
      chk_ref(QDRPC_REF_AUTO, 1'b1);
      for (int c = 0; c < 4; c++) begin
         chk("chanCode", {8'h0, chanCode[c]}, 24'h0);
         chk("chanPdMode", {22'h0, chanPdMode[c]}, 24'h0);
      end
   endtask : t_reset_values
   // each channel keeps its own code, boundary codes included
   task automatic t_codes();
      logic [15:0] codes [4];
      codes = '{16'hffff, 16'h0000, 16'h8001, 16'h1234};
      for (int c = 0; c < 4; c++) begin
         chan(c[1:0], 1'b0, codes[c]);
      end
      for (int c = 0; c < 4; c++) begin
         chk("chCode", 24'(chanCode[c]), 24'(codes[c]));
      end
   endtask : t_codes
   // short frame ignored, then off, channels still load, then restore
   task automatic t_off_and_restore();
      qdrpc_host_model_inst.send(REF_OFF_CMD, 20);
      chk_ref(QDRPC_REF_AUTO, 1'b1);
      qdrpc_host_model_inst.send(REF_OFF_CMD, 24);
      chk_ref(QDRPC_REF_OFF, 1'b0);
      chan(2'h1, 1'b0, 16'h0f0f);
      chk("chanCode", {8'h0, chanCode[1]}, 24'h000f0f);
      qdrpc_host_model_inst.send(AUTO_WORD, 24);
      chk_ref(QDRPC_REF_AUTO, 1'b1);
   endtask : t_off_and_restore
   // automatic mode follows the channels' power state
   task automatic t_auto_follow();
      for (int c = 0; c < 4; c++) begin
         chan(c[1:0], 1'b1, {2'(c % 3 + 1), 14'h0});
         chk("chanPdMode", {22'h0, chanPdMode[c]}, 24'(c % 3 + 1));
         chk_ref(QDRPC_REF_AUTO, c < 3);
      end
      chk("chanCode", {8'h0, chanCode[3]}, 24'h001234);
      chan(2'h2, 1'b0, 16'h00aa);
      chk_ref(QDRPC_REF_AUTO, 1'b1);
      chan(2'h2, 1'b1, 16'hc000);
      chk_ref(QDRPC_REF_AUTO, 1'b0);
   endtask : t_auto_follow
   // forced on ignores channel power, restore returns to following
   task automatic t_force_on();
      qdrpc_host_model_inst.send(REF_ON_CMD, 24);
      chk_ref(QDRPC_REF_ON, 1'b1);
      qdrpc_host_model_inst.send(AUTO_WORD, 24);
      chk_ref(QDRPC_REF_AUTO, 1'b0);
   endtask : t_force_on
   // store, simultaneous and broadcast loads, and a foreign address
   task automatic t_load_ops();
      qdrpc_host_model_inst.send(24'h344321, 24); // broadcast code
      for (int c = 0; c < 4; c++) begin
         chk("bcCode", 24'(chanCode[c]), 24'h004321);
         chk("bcPd", 24'(chanPdMode[c]), 24'h0);
      end
      qdrpc_host_model_inst.send(24'h025555, 24); // stage channel B
      chk("storeCode", 24'(chanCode[1]), 24'h004321);
      qdrpc_host_model_inst.send(24'h507777, 24); // other address
      chk("addrCode", 24'(chanCode[0]), 24'h004321);
      qdrpc_host_model_inst.send(24'h242222, 24); // simultaneous load
      chk("simCodeB", 24'(chanCode[1]), 24'h005555);
      chk("simCodeC", 24'(chanCode[2]), 24'h002222);
      chk("simCodeA", 24'(chanCode[0]), 24'h004321);
      qdrpc_host_model_inst.send(24'h358000, 24); // all power down
      for (int c = 0; c < 4; c++) begin
         chk("bcPdDown", 24'(chanPdMode[c]), 24'h2);
      end
      chk_ref(QDRPC_REF_AUTO, 1'b0);
      qdrpc_host_model_inst.send(24'h066666, 24); // stage channel D
      qdrpc_host_model_inst.send(24'h309999, 24); // live from staged
      chk("bcLoadD", 24'(chanCode[3]), 24'h006666);
      chk("bcLoadA", 24'(chanCode[0]), 24'h004321);
      chk("bcPdA", 24'(chanPdMode[0]), 24'h2);
      chk("bcPdD", 24'(chanPdMode[3]), 24'h0);
      chk_ref(QDRPC_REF_AUTO, 1'b1);
   endtask : t_load_ops
   // power cycle from the disabled setting
   task automatic t_power_cycle();
      qdrpc_host_model_inst.send(REF_OFF_CMD, 24);
      chk_ref(QDRPC_REF_OFF, 1'b0);
      do_reset();
      t_reset_values();
   endtask : t_power_cycle
   // watchdog against a hung run
   initial begin
      #300us;
      n_errors++;
      stop_test();
   end
   // main sequence
   initial begin
      do_reset();
      t_reset_values();
      t_codes();
      t_off_and_restore();
      t_auto_follow();
      t_force_on();
      t_load_ops();
      t_power_cycle();
      stop_test();
   end
endmodule : tb_qdrpc_top
